//--- charger_hot_zone_pkg.sv
// constants for the hot-zone charger control register
package charger_hot_zone_pkg;
	// register location
	localparam logic [7:0] HOT_ZONE_CTRL_ADDR = 8'h09;
	// reset value: reserved bit and recharge enable set
	localparam logic [7:0] HOT_ZONE_CTRL_RESET = 8'hC0;
	// mask of bits that software may write
	localparam logic [7:0] HOT_ZONE_CTRL_WMASK = 8'h7F;
	// value returned for any other address
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// field positions
	localparam int RESERVED_BIT = 7;
	localparam int RECHARGE_EN_BIT = 6;
	localparam int TERM_DIS_BIT = 5;
	localparam int VSEL_LSB = 3;
	localparam int VSEL_W = 2;
	localparam int ISEL_LSB = 0;
	localparam int ISEL_W = 3;
	// reserved bit fixed level
	localparam logic RESERVED_LEVEL = 1'b1;
	// field reset values
	localparam logic RECHARGE_EN_RESET = 1'b1;
	localparam logic TERM_DIS_RESET = 1'b0;
	localparam logic [1:0] VSEL_RESET = 2'h0;
	localparam logic [2:0] ISEL_RESET = 3'h0;
	// decoded width: termination voltage in millivolts
	localparam int VOLT_MV_W = 12;
	// termination feedback voltage per code, in millivolts
	localparam logic [11:0] TERM_MV_00 = 12'h7D0;
	localparam logic [11:0] TERM_MV_01 = 12'h802;
	localparam logic [11:0] TERM_MV_10 = 12'h81B;
	localparam logic [11:0] TERM_MV_11 = 12'h834;
	// decoded width: current limit in tenths of a percent
	localparam int PERMILLE_W = 10;
	// fast-charge limit per code, tenths of a percent of programmed current
	localparam logic [9:0] ILIM_000 = 10'h000;
	localparam logic [9:0] ILIM_001 = 10'h0FA;
	localparam logic [9:0] ILIM_010 = 10'h177;
	localparam logic [9:0] ILIM_011 = 10'h1F4;
	localparam logic [9:0] ILIM_100 = 10'h271;
	localparam logic [9:0] ILIM_101 = 10'h2EE;
	localparam logic [9:0] ILIM_110 = 10'h36B;
	localparam logic [9:0] ILIM_111 = 10'h36B;
endpackage

//--- hot_zone_sel_if.sv
// carrier between the register bank and its selection decoder
`timescale 1ns/1ps
interface hot_zone_sel_if;
	logic [charger_hot_zone_pkg::VSEL_W-1:0] volt_sel; // termination voltage code
	logic [charger_hot_zone_pkg::ISEL_W-1:0] curr_sel; // current limit code
	logic [charger_hot_zone_pkg::VOLT_MV_W-1:0] volt_mv; // decoded voltage
	logic [charger_hot_zone_pkg::PERMILLE_W-1:0] curr_permille; // decoded limit
	// register side drives codes, reads decoded values
	modport bank (output volt_sel, output curr_sel, input volt_mv, input curr_permille);
	// decoder side
	modport decode (input volt_sel, input curr_sel, output volt_mv, output curr_permille);
endinterface

//--- hot_zone_sel_decode.sv
// decodes hot-zone selection codes into voltage and current-limit values
`timescale 1ns/1ps
module hot_zone_sel_decode (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	hot_zone_sel_if.decode sel
);
	// termination voltage lookup, registered
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sel.volt_mv <= charger_hot_zone_pkg::TERM_MV_00;
		end else begin
			case (sel.volt_sel)
				2'h0: sel.volt_mv <= charger_hot_zone_pkg::TERM_MV_00;
				2'h1: sel.volt_mv <= charger_hot_zone_pkg::TERM_MV_01;
				2'h2: sel.volt_mv <= charger_hot_zone_pkg::TERM_MV_10;
				2'h3: sel.volt_mv <= charger_hot_zone_pkg::TERM_MV_11;
				default: sel.volt_mv <= charger_hot_zone_pkg::TERM_MV_00;
			endcase
		end
	end

	// fast-charge current limit lookup, registered
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sel.curr_permille <= charger_hot_zone_pkg::ILIM_000;
		end else begin
			case (sel.curr_sel)
				3'h0: sel.curr_permille <= charger_hot_zone_pkg::ILIM_000;
				3'h1: sel.curr_permille <= charger_hot_zone_pkg::ILIM_001;
				3'h2: sel.curr_permille <= charger_hot_zone_pkg::ILIM_010;
				3'h3: sel.curr_permille <= charger_hot_zone_pkg::ILIM_011;
				3'h4: sel.curr_permille <= charger_hot_zone_pkg::ILIM_100;
				3'h5: sel.curr_permille <= charger_hot_zone_pkg::ILIM_101;
				3'h6: sel.curr_permille <= charger_hot_zone_pkg::ILIM_110;
				3'h7: sel.curr_permille <= charger_hot_zone_pkg::ILIM_111;
				default: sel.curr_permille <= charger_hot_zone_pkg::ILIM_000;
			endcase
		end
	end
endmodule

//--- charger_hot_zone_ctrl_reg.sv
// hot-zone charger control register with recharge and termination gating
`timescale 1ns/1ps
// Summary of operation
// - enable bit allows auto recharge on low voltage
// - disable bit keeps charging despite low current
// - two-bit code selects termination feedback voltage
// - three-bit code selects fast-charge current limit
module charger_hot_zone_ctrl_reg (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// register bus from the serial interface logic, same clock
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// detector levels from the charger analog side, asynchronous
	input wire logic low_batt_voltage_i,
	input wire logic low_charge_current_i,
	// field values to the charger state machine
	output logic auto_recharge_enable_o,
	output logic low_current_termination_disable_o,
	output logic [1:0] hot_zone_term_voltage_sel_o,
	output logic [2:0] hot_zone_charge_current_sel_o,
	// decoded selections, one cycle behind the codes
	output logic [11:0] term_voltage_mv_o,
	output logic [9:0] charge_limit_permille_o,
	// single-cycle requests to the charger state machine
	output logic recharge_request_o,
	output logic terminate_request_o
);
	// stored writable fields
	// reserved bit has no flip-flop, it is tied in the image
	// fields survive until reset or a write to this address
	logic auto_recharge_enable_q; // recharge enable
	logic low_current_termination_disable_q; // termination disable
	logic [1:0] hot_zone_term_voltage_sel_q; // voltage code
	logic [2:0] hot_zone_charge_current_sel_q; // current code
	// read answer registers
	logic [7:0] rdata_q; // read data holding register
	logic rvalid_q; // read answer strobe
	// decode and image, combinational
	logic hit; // address matches this register
	logic [7:0] reg_value; // assembled register image
	// pin synchronisers, two stages each
	// third stage of each is the edge detector memory
	logic low_batt_meta_q;
	logic low_batt_sync_q;
	logic low_batt_prev_q; // previous synchronised level
	logic low_curr_meta_q;
	logic low_curr_sync_q;
	logic low_curr_prev_q;
	// request registers
	logic recharge_req_q; // one-cycle recharge request
	logic terminate_req_q; // one-cycle termination request

	// carrier to the selection decoder
	// codes go out, decoded values come back
	hot_zone_sel_if sel_bus ();

	// address decode
	// one register here; other addresses belong elsewhere
	// writes elsewhere are ignored, reads elsewhere answer zero
	assign hit = (reg_addr_i == charger_hot_zone_pkg::HOT_ZONE_CTRL_ADDR);

	// register image with fixed reserved bit
	// bit 7 is constant, so software always reads it as one
	// fields sit at their package positions
	// assembled every cycle, sampled only on a read strobe
	always_comb begin
		reg_value = 8'h00;
		reg_value[charger_hot_zone_pkg::RESERVED_BIT] = charger_hot_zone_pkg::RESERVED_LEVEL;
		reg_value[charger_hot_zone_pkg::RECHARGE_EN_BIT] = auto_recharge_enable_q;
		reg_value[charger_hot_zone_pkg::TERM_DIS_BIT] = low_current_termination_disable_q;
		reg_value[charger_hot_zone_pkg::VSEL_LSB +: charger_hot_zone_pkg::VSEL_W] =
			hot_zone_term_voltage_sel_q;
		reg_value[charger_hot_zone_pkg::ISEL_LSB +: charger_hot_zone_pkg::ISEL_W] =
			hot_zone_charge_current_sel_q;
	end

	// recharge enable field
	// reset leaves automatic recharge enabled
	// only a write to this address changes it
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			auto_recharge_enable_q <= charger_hot_zone_pkg::RECHARGE_EN_RESET;
		end else if (reg_wr_i && hit) begin
			auto_recharge_enable_q <= reg_wdata_i[charger_hot_zone_pkg::RECHARGE_EN_BIT];
		end
	end

	// termination disable field
	// reset leaves termination on low current active
	// only a write to this address changes it
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			low_current_termination_disable_q <= charger_hot_zone_pkg::TERM_DIS_RESET;
		end else if (reg_wr_i && hit) begin
			low_current_termination_disable_q <= reg_wdata_i[charger_hot_zone_pkg::TERM_DIS_BIT];
		end
	end

	// voltage and current selection fields; bit 7 has no storage
	// reset selects the lowest voltage and a zero current limit
	// every code is legal, so no write is refused
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			hot_zone_term_voltage_sel_q <= charger_hot_zone_pkg::VSEL_RESET;
			hot_zone_charge_current_sel_q <= charger_hot_zone_pkg::ISEL_RESET;
		end else if (reg_wr_i && hit) begin
			hot_zone_term_voltage_sel_q <=
				reg_wdata_i[charger_hot_zone_pkg::VSEL_LSB +: charger_hot_zone_pkg::VSEL_W];
			hot_zone_charge_current_sel_q <=
				reg_wdata_i[charger_hot_zone_pkg::ISEL_LSB +: charger_hot_zone_pkg::ISEL_W];
		end
	end

	// read path: answer one cycle after the read strobe
	// a write in the same cycle is seen only by the next read
	// read data holds the last answer until another read
	// answer strobe simply follows the read strobe
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_q <= charger_hot_zone_pkg::UNMAPPED_READ;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_i;
			if (reg_rd_i) begin
				// other addresses answer with zero
				rdata_q <= hit ? reg_value : charger_hot_zone_pkg::UNMAPPED_READ;
			end
		end
	end

	// low battery voltage pin synchroniser
	// two stages before any logic looks at the level
	// only the sync stage reads the meta stage
	// reset to the idle low level, so no false edge follows
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			low_batt_meta_q <= 1'b0;
			low_batt_sync_q <= 1'b0;
			low_batt_prev_q <= 1'b0;
		end else begin
			low_batt_meta_q <= low_batt_voltage_i;
			low_batt_sync_q <= low_batt_meta_q;
			low_batt_prev_q <= low_batt_sync_q;
		end
	end

	// low charge current pin synchroniser
	// two stages before any logic looks at the level
	// only the sync stage reads the meta stage
	// reset to the idle low level, so no false edge follows
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			low_curr_meta_q <= 1'b0;
			low_curr_sync_q <= 1'b0;
			low_curr_prev_q <= 1'b0;
		end else begin
			low_curr_meta_q <= low_charge_current_i;
			low_curr_sync_q <= low_curr_meta_q;
			low_curr_prev_q <= low_curr_sync_q;
		end
	end

	// recharge request on a new low-voltage detection, only when enabled
	// gate applies at the detection edge
	// a level held high gives one pulse only
	// the state machine must act on the single-cycle pulse
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			recharge_req_q <= 1'b0;
		end else begin
			recharge_req_q <= auto_recharge_enable_q && low_batt_sync_q && !low_batt_prev_q;
		end
	end

	// termination request on a new low-current detection, unless disabled
	// gate applies at the detection edge
	// a level held high gives one pulse only
	// the state machine must act on the single-cycle pulse
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			terminate_req_q <= 1'b0;
		end else begin
			terminate_req_q <= !low_current_termination_disable_q && low_curr_sync_q &&
				!low_curr_prev_q;
		end
	end

	// codes to the decoder
	// the decoder registers them, so values follow a cycle later
	assign sel_bus.volt_sel = hot_zone_term_voltage_sel_q;
	assign sel_bus.curr_sel = hot_zone_charge_current_sel_q;

	// selection decoder
	// shares this clock and reset
	hot_zone_sel_decode u_decode (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.sel(sel_bus.decode)
	);

	// outputs
	assign reg_rdata_o = rdata_q;
	assign reg_rvalid_o = rvalid_q;
	// field values
	assign auto_recharge_enable_o = auto_recharge_enable_q;
	assign low_current_termination_disable_o = low_current_termination_disable_q;
	assign hot_zone_term_voltage_sel_o = hot_zone_term_voltage_sel_q;
	assign hot_zone_charge_current_sel_o = hot_zone_charge_current_sel_q;
	// decoded values
	assign term_voltage_mv_o = sel_bus.volt_mv;
	assign charge_limit_permille_o = sel_bus.curr_permille;
	// requests
	assign recharge_request_o = recharge_req_q;
	assign terminate_request_o = terminate_req_q;
endmodule

//--- hz_reg_sva.sv
// port checks for the hot-zone control register
`timescale 1ns/1ps
module hz_reg_sva (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic low_batt_voltage_i,
	input wire logic low_charge_current_i,
	input wire logic auto_recharge_enable_o,
	input wire logic low_current_termination_disable_o,
	input wire logic [1:0] hot_zone_term_voltage_sel_o,
	input wire logic [2:0] hot_zone_charge_current_sel_o,
	input wire logic [11:0] term_voltage_mv_o,
	input wire logic [9:0] charge_limit_permille_o,
	input wire logic recharge_request_o,
	input wire logic terminate_request_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// writable fields in register order
	wire logic [6:0] f = {auto_recharge_enable_o, low_current_termination_disable_o,
		hot_zone_term_voltage_sel_o, hot_zone_charge_current_sel_o};
	// this register addressed
	wire logic sel = reg_addr_i == charger_hot_zone_pkg::HOT_ZONE_CTRL_ADDR;
	// decode tables
	localparam logic [11:0] MV_T [4] = '{12'h7D0, 12'h802, 12'h81B, 12'h834};
	localparam logic [9:0] PM_T [8] = '{10'h000, 10'h0FA, 10'h177, 10'h1F4,
		10'h271, 10'h2EE, 10'h36B, 10'h36B};
	// detection edge with its gate
	sequence s_rise(lvl, gate);
		$rose(lvl) && gate;
	endsequence
	// single-cycle request pulse
	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence
	a_read_map: assert property (reg_rd_i && sel |=> reg_rvalid_o
		&& reg_rdata_o == {1'b1, $past(f)}) else $error("mapped read wrong");
	a_read_unmap: assert property (reg_rd_i && !sel |=> reg_rvalid_o
		&& reg_rdata_o == 8'h00) else $error("unmapped read wrong");
	a_answer_only: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("read answer without read");
	a_write_fields: assert property (reg_wr_i && sel |=> f == $past(reg_wdata_i[6:0]))
		else $error("write not stored");
	a_fields_hold: assert property (!(reg_wr_i && sel) |=> $stable(f))
		else $error("fields changed without write");
	a_volt_decode: assert property (term_voltage_mv_o == MV_T[$past(hot_zone_term_voltage_sel_o)])
		else $error("voltage decode wrong");
	a_limit_decode: assert property (charge_limit_permille_o == PM_T[$past(hot_zone_charge_current_sel_o)])
		else $error("limit decode wrong");
	a_recharge_on: assert property (s_rise(low_batt_voltage_i, auto_recharge_enable_o)
		|-> ##[2:5] s_pulse(recharge_request_o)) else $error("recharge pulse missing");
	a_recharge_off: assert property (s_rise(low_batt_voltage_i, !auto_recharge_enable_o)
		|-> !recharge_request_o [*6]) else $error("recharge while disabled");
	a_term_on: assert property (s_rise(low_charge_current_i, !low_current_termination_disable_o)
		|-> ##[2:5] s_pulse(terminate_request_o)) else $error("terminate pulse missing");
	a_term_off: assert property (s_rise(low_charge_current_i, low_current_termination_disable_o)
		|-> !terminate_request_o [*6]) else $error("terminate while disabled");
endmodule
bind charger_hot_zone_ctrl_reg hz_reg_sva hz_reg_sva_inst (.*);

//--- test_charger_hot_zone_ctrl_reg.sv
// self-checking bench for the hot-zone control register
`timescale 1ns/1ps
module test_charger_hot_zone_ctrl_reg;
	logic clk_sys_i = 1'b0; // 25 MHz clock
	logic reset_i = 1'b1; // synchronous reset
	logic [7:0] addr = 8'h00; // bus address
	logic wr = 1'b0; // write strobe
	logic [7:0] wdata = 8'h00; // write data
	logic rd = 1'b0; // read strobe
	logic lb = 1'b0; // low battery level
	logic lc = 1'b0; // low current level
	logic [7:0] rdata; // read data
	logic rvalid, en, dis, rech, term; // answer, fields, requests
	logic [1:0] vsel; // voltage code
	logic [2:0] isel; // limit code
	logic [11:0] mv; // decoded voltage
	logic [9:0] pm; // decoded limit
	logic [7:0] shadow = 8'hC0; // expected content
	logic [7:0] d, a; // scratch data and address
	integer n_errors = 0, comparisons = 0, seed = 60, i, k, np, nt;
	always #20 clk_sys_i = ~clk_sys_i; // half period
	charger_hot_zone_ctrl_reg charger_hot_zone_ctrl_reg_inst (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .low_batt_voltage_i(lb),
		.low_charge_current_i(lc), .auto_recharge_enable_o(en),
		.low_current_termination_disable_o(dis), .hot_zone_term_voltage_sel_o(vsel),
		.hot_zone_charge_current_sel_o(isel), .term_voltage_mv_o(mv),
		.charge_limit_permille_o(pm), .recharge_request_o(rech), .terminate_request_o(term));
	// expected voltage in mV
	function automatic logic [11:0] exp_mv(input logic [1:0] c);
		return (c == 2'h0) ? 12'd2000 : 12'd2025 + 12'd25 * c;
	endfunction
	// expected limit in tenths of a percent
	function automatic logic [9:0] exp_pm(input logic [2:0] c);
		return (c == 3'h0) ? 10'd0 : (c == 3'h7) ? 10'd875 : 10'd125 * (c + 10'd1);
	endfunction
	// compare and count
	task check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// report and stop
	task complete_run;
		$display("mismatches %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one bus cycle, strobes up for one edge
	task access(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clk_sys_i);
		#1;
		wr = w;
		rd = r;
		addr = ad;
		wdata = dt;
		@(posedge clk_sys_i);
		#1;
		wr = 1'b0;
		rd = 1'b0;
	endtask
	// read and compare the answer
	task rd_check(input logic [7:0] ad, input logic [7:0] exp);
		access(1'b0, 1'b1, ad, 8'h00);
		check(rvalid, 1'b1, "read answer");
		check(rdata, exp, "read data");
		@(posedge clk_sys_i);
		#1;
		check(rvalid, 1'b0, "read answer one cycle");
		check(rdata, exp, "read data held");
	endtask
	// field ports, decodes and readback
	task fields_check;
		check({en, dis, vsel, isel}, shadow[6:0], "field ports");
		@(posedge clk_sys_i);
		#1;
		check(mv, exp_mv(shadow[4:3]), "voltage decode");
		check(pm, exp_pm(shadow[2:0]), "limit decode");
		rd_check(8'h09, {1'b1, shadow[6:0]});
	endtask
	// hang guard
	initial begin
		#200000;
		n_errors++;
		complete_run;
	end
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys_i);
		#1;
		reset_i = 1'b0;
		fields_check;
		$display("test reset values done");
		for (i = 0; i < 8; i++) begin
			d = {1'b1, i[0], ~i[0], i[1:0], i[2:0]}; // every code, bit 7 set
			access(1'b1, 1'b0, 8'h09, d);
			shadow = {1'b1, d[6:0]};
			fields_check;
		end
		$display("test all codes done");
		for (i = 0; i < 30; i++) begin
			d = 8'($random(seed));
			a = (($random(seed) & 3) == 0) ? 8'($random(seed)) : 8'h09;
			access(1'b1, 1'b0, a, d);
			if (a == 8'h09) shadow = {1'b1, d[6:0]};
			else rd_check(a, 8'h00);
			fields_check;
		end
		access(1'b1, 1'b1, 8'h09, 8'h00); // write and read together
		check(rdata, {1'b1, shadow[6:0]}, "old value on joint read");
		shadow = 8'h80;
		fields_check;
		$display("test random access done");
		access(1'b1, 1'b0, 8'h09, 8'h3F); // non-reset content before a mid-run reset
		@(posedge clk_sys_i);
		#1;
		reset_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		reset_i = 1'b0;
		shadow = 8'hC0;
		check(rvalid, 1'b0, "answer cleared by reset");
		check(rdata, 8'h00, "read data cleared by reset");
		fields_check;
		$display("test mid-run reset done");
		for (i = 0; i < 4; i++) begin
			d = {1'b0, i[0], i[1], 5'h00};
			access(1'b1, 1'b0, 8'h09, d);
			repeat (3) @(posedge clk_sys_i);
			#1;
			lb = 1'b1;
			lc = 1'b1;
			np = 0;
			nt = 0;
			for (k = 0; k < 10; k++) begin
				@(posedge clk_sys_i);
				#1;
				if (rech !== 1'b0) np++;
				if (term !== 1'b0) nt++;
			end
			check(12'(np), i[0], "recharge pulse count");
			check(12'(nt), !i[1], "terminate pulse count");
			lb = 1'b0;
			lc = 1'b0;
			repeat (5) @(posedge clk_sys_i);
		end
		$display("test detection done");
		complete_run;
	end
endmodule
